// *** core/lcdm_map.svh ***
// Named offsets, field codes and timing counts for the LCD memory block.
// Included by the package and by the bench; holds definitions only.
`ifndef LCDM_MAP_SVH
`define LCDM_MAP_SVH

`define LCDM_ADDR_W        5
`define LCDM_NUM_ADDR      32
`define LCDM_NIB_W         4
`define LCDM_ARG_W         16
`define LCDM_PRE_W         11
`define LCDM_BLINK_W       17

// Division select codes.
`define LCDM_MODE_DIV4     2'b00
`define LCDM_MODE_STATIC   2'b01
`define LCDM_MODE_DIV3     2'b10
`define LCDM_MODE_DIV2     2'b11

// Pointer steps after one data byte.
`define LCDM_STEP_STATIC   5'h04
`define LCDM_STEP_DIV2     5'h04
`define LCDM_STEP_DIV3     5'h03
`define LCDM_STEP_DIV4     5'h02
`define LCDM_STEP_SEG14    5'h04
`define LCDM_STEP_ONE      5'h01
`define LCDM_STEP_NONE     5'h00

// Slot length masks: 2^7, 2^8, 2^9 and 2^11 oscillator cycles.
`define LCDM_MASK_R0       11'h07f
`define LCDM_MASK_R1       11'h0ff
`define LCDM_MASK_R2       11'h1ff
`define LCDM_MASK_R3       11'h7ff

// Last common index per mode.
`define LCDM_LAST_STATIC   2'h0
`define LCDM_LAST_DIV2     2'h1
`define LCDM_LAST_DIV3     2'h2
`define LCDM_LAST_DIV4     2'h3

// Blink half-period taps: bit 16 gives fosc/2^17, bit 15 fosc/2^16.
`define LCDM_BLINK_SLOW    17
`define LCDM_BLINK_FAST_DN 1

`endif

// *** core/lcdm_pkg.sv ***
// Types shared by the LCD display memory block and its bench.
// Assumes lcdm_map.svh is on the include path.
`include "lcdm_map.svh"

package lcdm_pkg;

   typedef enum logic [3:0] {
      LCDM_OP_BYTE      = 4'h0,
      LCDM_OP_SEG7      = 4'h1,
      LCDM_OP_SEG14     = 4'h2,
      LCDM_OP_NIBBLE    = 4'h3,
      LCDM_OP_LOAD_PTR  = 4'h4,
      LCDM_OP_BLINK_WR  = 4'h5,
      LCDM_OP_BLINK_AND = 4'h6,
      LCDM_OP_BLINK_OR  = 4'h7
   } lcdm_op_type;

   typedef struct packed {
      lcdm_op_type                op;
      logic [`LCDM_ARG_W-1:0]     arg;
   } lcdm_cmd_type;

   typedef logic [`LCDM_NUM_ADDR-1:0][`LCDM_NIB_W-1:0] lcdm_mem_type;

   typedef struct packed {
      lcdm_mem_type               mem;
      lcdm_mem_type               blink;
      lcdm_mem_type               latch;
      lcdm_mem_type               blink_latch;
      logic [`LCDM_ADDR_W-1:0]    ptr;
      logic                       cs_q;
      logic [`LCDM_PRE_W-1:0]     pre;
      logic [1:0]                 com;
      logic                       pol;
      logic [`LCDM_BLINK_W-1:0]   blink_cnt;
      logic [`LCDM_NUM_ADDR-1:0]  seg;
      logic [3:0]                 com_sel;
      logic                       sync_oe;
   } lcdm_state_type;

endpackage

// *** core/lcdm_top.sv ***
// LCD display memory, blink memory, display latch and drive timing.
// Assumes bytes arrive already deframed (and decoded where asked) as
// commands, and that mode bits are held steady by the command decoder.
// Contract
// - 32x4 display memory written by bytes or immediates.
// - Static: low nibble to bit0, pointer +4.
// - Bits used per address follow the mode.
// - Two-way: even bits bit0, odd bit1, +4.
// - Three-way: bits 0-2, n+2 bit2 zero, +3.
// - Three-way decoded: also zero bit2 of n.
// - Four-way: two full nibbles, pointer +2.
// - Four-way seven-segment: zero bit3 of n.
// - Four-way fourteen-segment: four addresses, forced zeros, +4.
// - Display on: latch drives segments per common.
// - One 5-bit pointer addresses both memories.
// - Pointer loaded by command, cleared on select fall.
// - Pointer wraps from 31 to 0.
// - Blink bit 1 makes that segment blink.
// - Blink memory write, AND and OR commands.
// - Blink memory copied with data, combined at output.
// - Latch 1 select level, 0 non-select.
// - Commons activated in turn, count per mode.
// - Active-low wired-OR sync line driven.
// - Frame is fosc/2^k divided by commons.
// - Blink rate chosen by one bit.
// - Rate bit: 2^17 clear, 2^16 set.
// - Division codes 00/10/11/01 select modes.
`timescale 1ns/1ps

module lcdm_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 count;
      logic                        room;
   } lcdm_fifo_state_type;

   lcdm_fifo_state_type fifo_reg;
   lcdm_fifo_state_type fifo_next;
   logic                push;
   logic                pop;

   assign push      = in_valid & fifo_reg.room;
   assign pop       = out_ready & (fifo_reg.count != '0);
   assign in_ready  = fifo_reg.room;
   assign out_valid = fifo_reg.count != '0;
   assign out_data  = fifo_reg.mem[fifo_reg.rd];

   always_comb begin
      fifo_next = fifo_reg;
      if (push) begin
         fifo_next.mem[fifo_reg.wr] = in_data;
         fifo_next.wr = fifo_reg.wr + 1'b1;
      end
      if (pop) begin
         fifo_next.rd = fifo_reg.rd + 1'b1;
      end
      fifo_next.count = fifo_reg.count + (AW+1)'(push) - (AW+1)'(pop);
      fifo_next.room = fifo_next.count != (AW+1)'(DEPTH);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fifo_reg <= '0;
         fifo_reg.room <= 1'b1;
      end else begin
         fifo_reg <= fifo_next;
      end
   end
endmodule

module lcdm_top
   import lcdm_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int BLINK_TAP  = `LCDM_BLINK_SLOW
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   input  wire logic                      cmd_valid,
   output logic                           cmd_ready,
   input  wire lcdm_cmd_type              cmd,
   input  wire logic                      cs_n,
   input  wire logic [1:0]                division_sel,
   input  wire logic [1:0]                frame_ratio_sel,
   input  wire logic                      blink_rate_sel,
   input  wire logic                      blink_en,
   input  wire logic                      display_on,
   output logic [`LCDM_NUM_ADDR-1:0]      segment_outputs,
   output logic [3:0]                     common_outputs,
   output logic                           drive_polarity,
   input  wire logic                      sync_n_in,
   output logic                           sync_n_out,
   output logic                           sync_n_oe,
   output logic [`LCDM_ADDR_W-1:0]        write_pointer
);
   lcdm_state_type              s_reg;
   lcdm_state_type              s_next;
   lcdm_cmd_type                q_cmd;
   logic                        q_valid;
   logic                        drain;
   logic                        take;
   logic [`LCDM_PRE_W-1:0]      mask;
   logic [1:0]                  last_com;
   logic                        slot_end;
   logic                        phase;

   // Draining stalls while chip select is high, so the queue really fills
   // when the host keeps sending between select windows.
   assign drain = ~cs_n & ~s_reg.cs_q;
   assign take  = q_valid & drain;

   lcdm_fifo #(
      .WIDTH ($bits(lcdm_cmd_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .in_data   (cmd),
      .out_valid (q_valid),
      .out_ready (drain),
      .out_data  (q_cmd)
   );

   always_comb begin
      unique case (frame_ratio_sel)
         2'b00: mask = `LCDM_MASK_R0;
         2'b01: mask = `LCDM_MASK_R1;
         2'b10: mask = `LCDM_MASK_R2;
         2'b11: mask = `LCDM_MASK_R3;
      endcase
      unique case (division_sel)
         `LCDM_MODE_DIV4:   last_com = `LCDM_LAST_DIV4;
         `LCDM_MODE_DIV3:   last_com = `LCDM_LAST_DIV3;
         `LCDM_MODE_DIV2:   last_com = `LCDM_LAST_DIV2;
         `LCDM_MODE_STATIC: last_com = `LCDM_LAST_STATIC;
      endcase
   end

   assign slot_end = (s_reg.pre & mask) == mask;
   assign phase = blink_rate_sel ?
      s_reg.blink_cnt[BLINK_TAP-1-`LCDM_BLINK_FAST_DN] :
      s_reg.blink_cnt[BLINK_TAP-1];

   always_comb begin
      logic [`LCDM_ADDR_W-1:0] step;
      logic [`LCDM_ADDR_W-1:0] a;
      logic [8:0]              t;
      logic [7:0]              b;
      step = `LCDM_STEP_NONE;
      a = '0;
      b = q_cmd.arg[7:0];
      t = {1'b0, b};
      s_next = s_reg;
      s_next.cs_q = cs_n;
      if (s_reg.cs_q & ~cs_n) begin
         s_next.ptr = '0;
      end
      if (~s_reg.cs_q & cs_n) begin
         s_next.latch = s_reg.mem;
         s_next.blink_latch = blink_en ? s_reg.blink : '0;
      end
      if (take) begin
         unique case (q_cmd.op)
            LCDM_OP_BYTE, LCDM_OP_SEG7: begin
               unique case (division_sel)
                  `LCDM_MODE_STATIC: begin
                     if (q_cmd.op == LCDM_OP_BYTE) begin
                        for (int i = 0; i < 4; i++) begin
                           a = s_reg.ptr + `LCDM_ADDR_W'(i);
                           s_next.mem[a][0] = b[i];
                        end
                        step = `LCDM_STEP_STATIC;
                     end
                  end
                  `LCDM_MODE_DIV2: begin
                     if (q_cmd.op == LCDM_OP_BYTE) begin
                        for (int i = 0; i < 4; i++) begin
                           a = s_reg.ptr + `LCDM_ADDR_W'(i);
                           s_next.mem[a][1:0] = b[2*i +: 2];
                        end
                        step = `LCDM_STEP_DIV2;
                     end
                  end
                  `LCDM_MODE_DIV3: begin
                     for (int i = 0; i < 3; i++) begin
                        a = s_reg.ptr + `LCDM_ADDR_W'(i);
                        s_next.mem[a][2:0] = t[3*i +: 3];
                     end
                     if (q_cmd.op == LCDM_OP_SEG7) begin
                        s_next.mem[s_reg.ptr][2] = 1'b0;
                     end
                     step = `LCDM_STEP_DIV3;
                  end
                  `LCDM_MODE_DIV4: begin
                     for (int i = 0; i < 2; i++) begin
                        a = s_reg.ptr + `LCDM_ADDR_W'(i);
                        s_next.mem[a] = b[4*i +: 4];
                     end
                     if (q_cmd.op == LCDM_OP_SEG7) begin
                        s_next.mem[s_reg.ptr][3] = 1'b0;
                     end
                     step = `LCDM_STEP_DIV4;
                  end
               endcase
            end
            LCDM_OP_SEG14: begin
               // The wide pattern only fits the four-way layout.
               if (division_sel == `LCDM_MODE_DIV4) begin
                  for (int i = 0; i < 4; i++) begin
                     a = s_reg.ptr + `LCDM_ADDR_W'(i);
                     s_next.mem[a] = q_cmd.arg[4*i +: 4];
                  end
                  a = s_reg.ptr + `LCDM_ADDR_W'(2);
                  s_next.mem[a][3] = 1'b0;
                  a = s_reg.ptr + `LCDM_ADDR_W'(1);
                  s_next.mem[a][0] = 1'b0;
                  step = `LCDM_STEP_SEG14;
               end
            end
            LCDM_OP_NIBBLE: begin
               s_next.mem[s_reg.ptr] = q_cmd.arg[3:0];
               step = `LCDM_STEP_ONE;
            end
            LCDM_OP_LOAD_PTR: begin
               s_next.ptr = q_cmd.arg[`LCDM_ADDR_W-1:0];
            end
            LCDM_OP_BLINK_WR: begin
               s_next.blink[s_reg.ptr] = q_cmd.arg[3:0];
               step = `LCDM_STEP_ONE;
            end
            LCDM_OP_BLINK_AND: begin
               s_next.blink[s_reg.ptr] = s_reg.blink[s_reg.ptr] &
                                         q_cmd.arg[3:0];
               step = `LCDM_STEP_ONE;
            end
            LCDM_OP_BLINK_OR: begin
               s_next.blink[s_reg.ptr] = s_reg.blink[s_reg.ptr] |
                                         q_cmd.arg[3:0];
               step = `LCDM_STEP_ONE;
            end
            default: begin
            end
         endcase
         if (q_cmd.op != LCDM_OP_LOAD_PTR) begin
            s_next.ptr = s_reg.ptr + step;
         end
      end

      // Frame timing: each common holds for one slot of 2^k cycles.
      s_next.pre = s_reg.pre + `LCDM_PRE_W'(1);
      s_next.blink_cnt = s_reg.blink_cnt + `LCDM_BLINK_W'(1);
      s_next.sync_oe = 1'b0;
      if (slot_end) begin
         if (s_reg.com >= last_com) begin
            s_next.com = '0;
            s_next.pol = ~s_reg.pol;
            s_next.sync_oe = 1'b1;
         end else begin
            s_next.com = s_reg.com + 2'h1;
         end
      end
      // Another chip pulling the shared line restarts our frame with it.
      if (~sync_n_in & ~s_reg.sync_oe) begin
         s_next.pre = `LCDM_PRE_W'(1);
         s_next.com = '0;
      end
      s_next.com_sel = 4'h1 << s_next.com;
      for (int g = 0; g < `LCDM_NUM_ADDR; g++) begin
         // Only bits below the common count are ever selected. Polarity is
         // folded in here so that the pins come straight from the flop.
         s_next.seg[g] = (display_on &
            s_next.latch[g][s_next.com] &
            ~(s_next.blink_latch[g][s_next.com] & phase)) ^
            s_next.pol;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.cs_q <= 1'b1;
         s_reg.com_sel <= 4'h1;
      end else begin
         s_reg <= s_next;
      end
   end

   // A segment pin that differs from drive_polarity is at select level.
   assign segment_outputs = s_reg.seg;
   assign common_outputs  = s_reg.com_sel;
   assign drive_polarity  = s_reg.pol;
   assign sync_n_oe       = s_reg.sync_oe;
   assign sync_n_out      = s_reg.com_sel[3] & ~s_reg.com_sel[3];
   assign write_pointer   = s_reg.ptr;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_ptr_load_cmd: assert property (
      take && q_cmd.op == LCDM_OP_LOAD_PTR |=> s_reg.ptr == $past(q_cmd.arg[4:0]))
      else $error("pointer load failed");
   a_ptr_cs_clear: assert property (
      s_reg.cs_q && !cs_n |=> s_reg.ptr == 5'h00)
      else $error("pointer not cleared on select fall");
   a_static_step: assert property (
      take && q_cmd.op == LCDM_OP_BYTE && division_sel == `LCDM_MODE_STATIC
      |=> s_reg.ptr == $past(s_reg.ptr) + 5'h04)
      else $error("static step wrong");
   a_div3_step: assert property (
      take && q_cmd.op == LCDM_OP_BYTE && division_sel == `LCDM_MODE_DIV3
      |=> s_reg.ptr == $past(s_reg.ptr) + 5'h03
          && s_reg.mem[$past(s_reg.ptr) + 5'h02][2] == 1'b0)
      else $error("three-way write wrong");
   a_div4_step: assert property (
      take && q_cmd.op == LCDM_OP_BYTE && division_sel == `LCDM_MODE_DIV4
      |=> s_reg.ptr == $past(s_reg.ptr) + 5'h02
          && s_reg.mem[$past(s_reg.ptr)] == $past(q_cmd.arg[3:0]))
      else $error("four-way write wrong");
   a_latch_copy: assert property (
      !s_reg.cs_q && cs_n |=> s_reg.latch == $past(s_reg.mem))
      else $error("latch copy missing");
   a_display_off: assert property (
      !display_on ##1 1
      |-> segment_outputs == {`LCDM_NUM_ADDR{drive_polarity}})
      else $error("segments active while display off");
   a_com_order: assert property (
      slot_end && sync_n_in && s_reg.com < last_com
      |=> $onehot(common_outputs) && s_reg.com == $past(s_reg.com) + 2'h1)
      else $error("common select out of order");
   a_sync_frame: assert property (
      sync_n_oe |-> common_outputs == 4'h1 && !sync_n_out)
      else $error("sync pulse outside frame start");

   c_seg14_write: cover property (
      take && q_cmd.op == LCDM_OP_SEG14 && division_sel == `LCDM_MODE_DIV4);
   c_fifo_full: cover property (!cmd_ready ##1 cs_n ##1 !cs_n);
   c_ptr_wrap: cover property (
      s_reg.ptr > 5'h1b && take ##1 s_reg.ptr < 5'h04);
   c_blink_seg: cover property (display_on && blink_en && phase);
endmodule

// *** testbench/lcdm_glass.sv ***
// Segment glass model: records which segments the drive selects per common.
// Assumes one-hot commons and a sync line that is low at frame start.
`timescale 1ns/1ps

module lcdm_glass
   import lcdm_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic [31:0] segment_outputs,
   input  wire logic [3:0]  common_outputs,
   input  wire logic        drive_polarity,
   input  wire logic        sync_n,
   output lcdm_mem_type     img,
   output lcdm_mem_type     blk,
   output logic             frame_done
);
   lcdm_mem_type on_acc;
   lcdm_mem_type off_acc;
   logic [31:0]  sel;

   // A segment seen both on and off within one frame is blinking.
   always @(posedge core_clk) begin
      frame_done <= 1'b0;
      if (!sync_n) begin
         img <= on_acc;
         blk <= on_acc & off_acc;
         frame_done <= 1'b1;
         on_acc = '0;
         off_acc = '0;
      end
      sel = segment_outputs ^ {32{drive_polarity}};
      for (int c = 0; c < 4; c++) begin
         if (common_outputs[c]) begin
            for (int g = 0; g < 32; g++) begin
               on_acc[g][c] = on_acc[g][c] | sel[g];
               off_acc[g][c] = off_acc[g][c] | ~sel[g];
            end
         end
      end
   end
endmodule

// *** testbench/test_lcdm_top.sv ***
// Self-checking bench for the LCD display memory and drive block.
// Assumes the package and map header compiled first; glass model beside.
`timescale 1ns/1ps
`include "lcdm_map.svh"

module test_lcdm_top
   import lcdm_pkg::*;
;
   typedef struct packed {
      lcdm_mem_type            img;
      lcdm_mem_type            blk;
      logic [`LCDM_ADDR_W-1:0] ptr;
      logic [15:0]             len;
   } lcdm_note_type;

   logic          core_clk, rst, cmd_valid, cmd_ready, cs_n, frame_done;
   logic          blink_rate_sel, blink_en, display_on, drive_polarity;
   logic          sync_n_in, sync_n_out, sync_n_oe;
   lcdm_cmd_type  cmd;
   logic [1:0]    division_sel, frame_ratio_sel;
   logic [31:0]   segment_outputs;
   logic [3:0]    common_outputs;
   logic [4:0]    write_pointer, ref_p;
   lcdm_mem_type  img, blk, ref_mem, ref_blk;
   lcdm_note_type note_q[$];
   int            n_fail, n_checks;

   lcdm_top #(.FIFO_DEPTH(16), .BLINK_TAP(4)) lcdm_top_i (
      .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .cs_n(cs_n),
      .division_sel(division_sel), .frame_ratio_sel(frame_ratio_sel),
      .blink_rate_sel(blink_rate_sel), .blink_en(blink_en),
      .display_on(display_on), .segment_outputs(segment_outputs),
      .common_outputs(common_outputs), .drive_polarity(drive_polarity),
      .sync_n_in(sync_n_in), .sync_n_out(sync_n_out),
      .sync_n_oe(sync_n_oe), .write_pointer(write_pointer));

   // The sync line is wired-OR with a pull-up.
   assign sync_n_in = sync_n_oe ? sync_n_out : 1'b1;

   lcdm_glass lcdm_glass_i (
      .core_clk(core_clk), .segment_outputs(segment_outputs),
      .common_outputs(common_outputs), .drive_polarity(drive_polarity),
      .sync_n(sync_n_in), .img(img), .blk(blk), .frame_done(frame_done));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic check_mem(string what, lcdm_mem_type e, lcdm_mem_type g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s exp %h got %h", what, e, g);
      end
   endtask

   task automatic check_ptr(logic [4:0] e, logic [4:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected write_pointer exp %h got %h", e, g);
      end
   endtask

   task automatic check_len(logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected frame_length exp %0d got %0d", e, g);
      end
   endtask

   task automatic check_bit(string what, logic e, logic g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s exp %b got %b", what, e, g);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic exec(lcdm_op_type op, logic [15:0] a);
      logic [8:0] x;
      logic [4:0] q;
      x = {1'b0, a[7:0]};
      case (op)
         LCDM_OP_BYTE, LCDM_OP_SEG7: begin
            if (op == LCDM_OP_SEG7 && division_sel[0]) return;
            for (int i = 0; i < 4; i++) begin
               q = ref_p + 5'(i);
               case (division_sel)
                  `LCDM_MODE_STATIC: ref_mem[q][0] = a[i];
                  `LCDM_MODE_DIV2: ref_mem[q][1:0] = a[2*i+:2];
                  `LCDM_MODE_DIV3: begin
                     if (i < 3) ref_mem[q][2:0] = x[3*i+:3];
                  end
                  default: if (i < 2) ref_mem[q] = a[4*i+:4];
               endcase
            end
            if (op == LCDM_OP_SEG7) begin
               ref_mem[ref_p][division_sel[1] ? 2 : 3] = 1'b0;
            end
            ref_p = ref_p + (division_sel == `LCDM_MODE_DIV3 ? 5'd3 :
                    division_sel == `LCDM_MODE_DIV4 ? 5'd2 : 5'd4);
         end
         LCDM_OP_SEG14: if (division_sel == `LCDM_MODE_DIV4) begin
            for (int i = 0; i < 4; i++) ref_mem[ref_p + 5'(i)] = a[4*i+:4];
            ref_mem[ref_p + 5'd2][3] = 1'b0;
            ref_mem[ref_p + 5'd1][0] = 1'b0;
            ref_p = ref_p + 5'd4;
         end
         LCDM_OP_NIBBLE: begin
            ref_mem[ref_p] = a[3:0];
            ref_p = ref_p + 5'd1;
         end
         LCDM_OP_LOAD_PTR: ref_p = a[4:0];
         LCDM_OP_BLINK_WR: begin
            ref_blk[ref_p] = a[3:0];
            ref_p = ref_p + 5'd1;
         end
         LCDM_OP_BLINK_AND: begin
            ref_blk[ref_p] = ref_blk[ref_p] & a[3:0];
            ref_p = ref_p + 5'd1;
         end
         default: begin
            ref_blk[ref_p] = ref_blk[ref_p] | a[3:0];
            ref_p = ref_p + 5'd1;
         end
      endcase
   endtask

   task automatic send(lcdm_op_type op, logic [15:0] a);
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd.op = op;
      cmd.arg = a;
      exec(op, a);
      do @(posedge core_clk); while (cmd_ready !== 1'b1);
      @(negedge core_clk);
      cmd_valid = 1'b0;
   endtask

   task automatic open_sess(logic [1:0] m, logic don, logic ben, logic hold);
      @(negedge core_clk);
      division_sel = m;
      display_on = don;
      blink_en = ben;
      blink_rate_sel = 1'($urandom);
      cs_n = hold;
      ref_p = '0;
      repeat (2) @(negedge core_clk);
   endtask

   // Waits out one frame so the glass records only fresh latch content.
   task automatic close_sess();
      lcdm_note_type n;
      int            k;
      logic [3:0]    nib;
      logic [15:0]   slot;
      repeat (40) @(negedge core_clk);
      cs_n = 1'b1;
      repeat (3) @(negedge core_clk);
      for (k = 0; k < 1100 && sync_n_in !== 1'b0; k++) @(negedge core_clk);
      repeat (2) @(negedge core_clk);
      case (division_sel)
         `LCDM_MODE_STATIC: nib = 4'h1;
         `LCDM_MODE_DIV2: nib = 4'h3;
         `LCDM_MODE_DIV3: nib = 4'h7;
         default: nib = 4'hf;
      endcase
      case (frame_ratio_sel)
         2'b00: slot = 16'(`LCDM_MASK_R0) + 16'h0001;
         2'b01: slot = 16'(`LCDM_MASK_R1) + 16'h0001;
         2'b10: slot = 16'(`LCDM_MASK_R2) + 16'h0001;
         default: slot = 16'(`LCDM_MASK_R3) + 16'h0001;
      endcase
      n.len = slot * 16'($countones(nib));
      n.img = ref_mem & {32{nib}} & {128{display_on}};
      n.blk = n.img & ref_blk & {128{blink_en}};
      n.ptr = ref_p;
      note_q.push_back(n);
      for (k = 0; k < 1100 && note_q.size() != 0; k++) @(negedge core_clk);
      if (note_q.size() != 0) begin
         n_fail++;
         note_q.delete();
         $display("unexpected frame exp 1 got 0");
      end
   endtask

   // Frame length and polarity are measured between successive frame ends.
   initial begin
      lcdm_note_type n;
      logic [15:0]   gap;
      logic          pol;
      gap = '0;
      pol = 1'b0;
      forever begin
         @(posedge core_clk);
         gap = gap + 16'h0001;
         if (frame_done === 1'b1 && note_q.size() > 0) begin
            n = note_q.pop_front();
            check_mem("image", n.img, img);
            check_mem("blink", n.blk, blk);
            check_ptr(n.ptr, write_pointer);
            check_len(n.len, gap);
            check_bit("drive_polarity", ~pol, drive_polarity);
            check_bit("sync_n_out", 1'b0, sync_n_out);
         end
         if (frame_done === 1'b1) begin
            gap = '0;
            pol = drive_polarity;
         end
      end
   end

   initial begin
      repeat (30000) @(posedge core_clk);
      n_fail++;
      $display("unexpected timeout exp 0 got 1");
      stop_test();
   end

   initial begin
      rst = 1'b1;
      cs_n = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      division_sel = 2'h0;
      frame_ratio_sel = 2'h0;
      blink_rate_sel = 1'b0;
      blink_en = 1'b0;
      display_on = 1'b0;
      ref_mem = '0;
      ref_blk = '0;
      ref_p = '0;
      n_fail = 0;
      n_checks = 0;
      void'($urandom(32'hf0afb493));
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      open_sess(`LCDM_MODE_DIV4, 1'b1, 1'b0, 1'b0);
      repeat (3) send(LCDM_OP_BYTE, 16'($urandom));
      send(LCDM_OP_SEG7, 16'h00ff);
      send(LCDM_OP_NIBBLE, 16'h000f);
      close_sess();
      // Static mode wraps past address 31 and drops seven-segment data.
      open_sess(`LCDM_MODE_STATIC, 1'b1, 1'b0, 1'b0);
      send(LCDM_OP_LOAD_PTR, 16'h001e);
      send(LCDM_OP_BYTE, 16'($urandom));
      send(LCDM_OP_SEG7, 16'h00ff);
      close_sess();
      frame_ratio_sel = 2'b01;
      open_sess(`LCDM_MODE_DIV2, 1'b1, 1'b0, 1'b0);
      repeat (2) send(LCDM_OP_BYTE, 16'($urandom));
      close_sess();
      frame_ratio_sel = 2'b00;
      open_sess(`LCDM_MODE_DIV3, 1'b1, 1'b0, 1'b0);
      send(LCDM_OP_BYTE, 16'h00ff);
      send(LCDM_OP_SEG7, 16'h00ff);
      send(LCDM_OP_BYTE, 16'($urandom));
      close_sess();
      open_sess(`LCDM_MODE_DIV4, 1'b1, 1'b1, 1'b0);
      send(LCDM_OP_SEG14, 16'hffff);
      send(LCDM_OP_LOAD_PTR, 16'h0000);
      send(LCDM_OP_BLINK_WR, 16'h000f);
      send(LCDM_OP_BLINK_WR, 16'($urandom));
      send(LCDM_OP_LOAD_PTR, 16'h0000);
      send(LCDM_OP_BLINK_AND, 16'h0005);
      send(LCDM_OP_BLINK_OR, 16'h0002);
      close_sess();
      open_sess(`LCDM_MODE_DIV4, 1'b0, 1'b0, 1'b0);
      send(LCDM_OP_NIBBLE, 16'h0009);
      close_sess();
      // Commands queue while deselected until the buffer refuses more.
      open_sess(`LCDM_MODE_DIV4, 1'b1, 1'b0, 1'b1);
      repeat (16) send(LCDM_OP_BYTE, 16'($urandom));
      check_bit("cmd_ready", 1'b0, cmd_ready);
      cs_n = 1'b0;
      close_sess();
      check_bit("cmd_ready", 1'b1, cmd_ready);
      stop_test();
   end
endmodule
